// ### rtl/pshwc_device.sv
// Purpose: Power-state sequencer of the transceiver, serial slave side
// Assumes: Link pins oversampled; sclk half period of 8+ system clocks
// Notes: Frame is 16 bits: write flag, 7-bit address, 8-bit data
//
// Functional notes
// [R1] Mode write sequences regulators before radio use
// [R2] Status register reports regulator ready flag
// [R3] Brown-out flag set when supply below 1.3 V
// [R4] Power-down turns core off, keeps registers
// [R5] Power-down blocks FIFO and loses its contents
// [R6] Registers stay reachable in power-down, slower clock
// [R7] Host uses 100 ns clock in power-down
// [R8] Deep sleep: everything off, registers lost
// [R9] Select low wakes deep sleep, full reset
// [R10] Slave output low during init, then high
// [R11] Oscillator off after power-up until mode asks
// [R12] Device is serial slave; configured only there
// [R13] Host: select high 100 ns, set/clear reset
// [R14] Power-on or soft reset restores all defaults
// [R15] Blocked FIFO ignores writes, reads return zero
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
module pshwc_device import pshwc_pkg::*; #(
   parameter int RAMP_CYCLES = RAMP_CYC,
   parameter int INIT_CYCLES = INIT_CYC,
   parameter int FIFO_DEPTH = 4
) (
   input wire logic i_sys_clk, // System clock
   input wire logic i_resetn, // Async reset, active low
   pshwc_spi_if.dev spi, // Serial link to host
   input wire logic i_vio_low, // Supply below brown-out level
   output logic o_core_on, // Core supplies enabled
   output logic o_osc_en, // Reference oscillator enabled
   output logic o_reg_ready, // Regulated supplies ready
   output logic o_rf_en, // Radio activity permitted
   output logic [3:0] o_mode // Current power mode
);
   // ----------------------------------------------------------------
   // Types and state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      DS_INIT, DS_DEEP, DS_PD, DS_RAMP, DS_ON
   } pshwc_dstate_e;
   localparam int TW = $clog2(RAMP_CYCLES + INIT_CYCLES + 1);
   localparam int AW = $clog2(FIFO_DEPTH);

   pshwc_dstate_e state, next_state;
   logic [TW-1:0] timer, next_timer;
   logic [4:0] bitcnt, next_bitcnt;
   logic [14:0] rxsh, next_rxsh;
   logic [7:0] txsh, next_txsh;
   logic miso_q, next_miso_q;
   logic [3:0] mode_q, next_mode_q;
   logic rst_q, next_rst_q;
   logic [7:0] scratch, next_scratch;
   logic brown_q, next_brown_q;
   logic [7:0] mem [FIFO_DEPTH];
   logic [7:0] next_mem [FIFO_DEPTH];
   logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
   logic [AW:0] fcnt, next_fcnt;
   logic sclk_m, sclk_s, sclk_p, cs_m, cs_s, mosi_m, mosi_s;
   logic vlow_m, vlow_s;
   logic rise, fall, live, fifo_ok, clr;
   logic [7:0] cmd, rd_val;
   logic [15:0] word;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_p <= 1'b0;
         cs_m <= 1'b1;
         cs_s <= 1'b1;
         mosi_m <= 1'b0;
         mosi_s <= 1'b0;
         vlow_m <= 1'b0;
         vlow_s <= 1'b0;
      end else begin
         sclk_m <= spi.sclk;
         sclk_s <= sclk_m;
         sclk_p <= sclk_s;
         cs_m <= spi.cs_n;
         cs_s <= cs_m;
         mosi_m <= spi.mosi;
         mosi_s <= mosi_m;
         vlow_m <= i_vio_low;
         vlow_s <= vlow_m;
      end
   end

   // No access while asleep or initialising
   assign live = (state != DS_DEEP) && (state != DS_INIT); // [R8] [R12]
   assign rise = live && !cs_s && sclk_s && !sclk_p && (bitcnt != 5'h10);
   assign fall = live && !cs_s && !sclk_s && sclk_p && bitcnt[3];
   assign fifo_ok = (state == DS_ON); // [R5]
   assign cmd = {rxsh[6:0], mosi_s};
   assign word = {rxsh, mosi_s};

   // ----------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------
   always_comb begin
      rd_val = 8'h00;
      case (cmd[6:0])
         ADDR_STATUS: begin
            rd_val[STAT_READY_BIT] = (state == DS_ON); // [R2]
            rd_val[STAT_BROWN_BIT] = brown_q; // [R3]
            rd_val[STAT_CORE_BIT] = o_core_on;
         end
         ADDR_MODE: rd_val = {rst_q, 3'b000, mode_q};
         ADDR_FIFO: begin
            rd_val = (fifo_ok && fcnt != '0) ? mem[rptr] : 8'h00; // [R15]
         end
         ADDR_FIFO_CNT: rd_val = 8'(fcnt);
         ADDR_SCRATCH: rd_val = scratch;
         default: rd_val = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer, slave and registers
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_timer = timer;
      next_bitcnt = bitcnt;
      next_rxsh = rxsh;
      next_txsh = txsh;
      next_miso_q = miso_q;
      next_mode_q = mode_q;
      next_rst_q = rst_q;
      next_scratch = scratch;
      next_brown_q = brown_q;
      next_mem = mem;
      next_wptr = wptr;
      next_rptr = rptr;
      next_fcnt = fcnt;
      clr = 1'b0;
      case (state)
         DS_INIT: begin
            if (timer >= TW'(INIT_CYCLES - 1)) begin
               next_state = DS_PD;
               next_timer = '0;
            end else begin
               next_timer = timer + 1'b1;
            end
         end
         DS_DEEP: begin
            // Contents wiped on wake; mode stays visible while asleep
            if (!cs_s) begin
               clr = 1'b1; // [R8]
               next_state = DS_INIT; // [R9]
               next_timer = '0;
            end
         end
         DS_PD: begin
            if (mode_q == MODE_DEEP && cs_s) begin
               next_state = DS_DEEP;
            end else if (mode_q != MODE_PD && mode_q != MODE_DEEP) begin
               next_state = DS_RAMP; // [R1]
               next_timer = '0;
            end
         end
         DS_RAMP: begin
            if (mode_q == MODE_PD || mode_q == MODE_DEEP) begin
               next_state = DS_PD; // [R4]
            end else if (timer >= TW'(RAMP_CYCLES - 1)) begin
               next_state = DS_ON; // [R1]
            end else begin
               next_timer = timer + 1'b1;
            end
         end
         DS_ON: begin
            if (mode_q == MODE_PD || mode_q == MODE_DEEP) begin
               next_state = DS_PD; // [R4]
            end
         end
         default: next_state = DS_INIT;
      endcase

      // Serial slave, mode 0
      if (cs_s || !live) begin
         next_bitcnt = '0;
         next_miso_q = 1'b1;
      end else if (rise) begin
         next_rxsh = word[14:0];
         next_bitcnt = bitcnt + 1'b1;
         if (bitcnt == 5'h07 && !cmd[7]) begin
            next_txsh = rd_val; // [R6]
            if (cmd[6:0] == ADDR_FIFO && fifo_ok && fcnt != '0) begin
               next_rptr = rptr + 1'b1;
               next_fcnt = fcnt - 1'b1;
            end
            if (cmd[6:0] == ADDR_STATUS) begin
               next_brown_q = 1'b0;
            end
         end
         if (bitcnt == 5'h0F && word[15]) begin
            if (word[14:8] == ADDR_MODE) begin
               if (word[MODE_RST_BIT]) begin
                  clr = 1'b1; // [R14]
               end else if (rst_q) begin
                  next_rst_q = 1'b0;
               end else begin
                  next_mode_q = word[3:0]; // [R1]
               end
            end else if (!rst_q && word[14:8] == ADDR_SCRATCH) begin
               next_scratch = word[7:0]; // [R6]
            end else if (!rst_q && word[14:8] == ADDR_FIFO && fifo_ok &&
                  fcnt != (AW+1)'(FIFO_DEPTH)) begin
               next_mem[wptr] = word[7:0]; // [R15]
               next_wptr = wptr + 1'b1;
               next_fcnt = fcnt + 1'b1;
            end
         end
      end else if (fall) begin
         next_miso_q = txsh[7];
         next_txsh = {txsh[6:0], 1'b0};
      end

      // FIFO contents lost whenever core is not fully up
      if (!fifo_ok) begin
         next_wptr = '0; // [R5]
         next_rptr = '0;
         next_fcnt = '0;
      end
      if (clr) begin
         next_mode_q = MODE_PD; // [R14]
         next_scratch = SCRATCH_RESET;
         next_brown_q = 1'b0;
         next_rst_q = 1'b0;
         next_wptr = '0;
         next_rptr = '0;
         next_fcnt = '0;
      end
      if (rise && bitcnt == 5'h0F && word[15] && word[14:8] == ADDR_MODE &&
            word[MODE_RST_BIT]) begin
         next_rst_q = 1'b1; // [R14]
      end
      // Supply event wins over clear-on-read
      if (vlow_s) begin
         next_brown_q = 1'b1; // [R3]
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= DS_INIT; // [R14]
         timer <= '0;
         bitcnt <= '0;
         rxsh <= '0;
         txsh <= '0;
         miso_q <= 1'b1;
         mode_q <= MODE_PD; // [R11]
         rst_q <= 1'b0;
         scratch <= SCRATCH_RESET;
         brown_q <= 1'b0;
         wptr <= '0;
         rptr <= '0;
         fcnt <= '0;
      end else begin
         state <= next_state;
         timer <= next_timer;
         bitcnt <= next_bitcnt;
         rxsh <= next_rxsh;
         txsh <= next_txsh;
         miso_q <= next_miso_q;
         mode_q <= next_mode_q;
         rst_q <= next_rst_q;
         scratch <= next_scratch;
         brown_q <= next_brown_q;
         wptr <= next_wptr;
         rptr <= next_rptr;
         fcnt <= next_fcnt;
      end
   end

   // FIFO storage has no reset
   always_ff @(posedge i_sys_clk) begin
      mem <= next_mem;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_core_on = (state == DS_INIT) || (state == DS_RAMP) ||
      (state == DS_ON); // [R4] [R8]
   assign o_osc_en = (state == DS_RAMP) || (state == DS_ON); // [R11]
   assign o_reg_ready = (state == DS_ON); // [R2]
   assign o_rf_en = (state == DS_ON) && (mode_q == MODE_RX ||
      mode_q == MODE_TX); // [R1]
   assign o_mode = mode_q;
   assign spi.miso_out = (state == DS_INIT) ? 1'b0 : miso_q; // [R10]
   assign spi.miso_oe = !cs_s && (state != DS_DEEP); // [R10]
endmodule

// ### rtl/pshwc_host.sv
// Purpose: Serial master that drives the power-state device
// Assumes: Software reaches the master over APB, one word per register
// Notes: Every frame is preceded by select held high for a minimum gap
`timescale 1ns/1ns
module pshwc_host import pshwc_pkg::*; #(
   parameter int HALF_FAST = 8,
   parameter int HALF_SLOW = 16
) (
   input wire logic i_sys_clk, // System clock
   input wire logic i_resetn, // Async reset, active low
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic i_pwrite, // APB direction
   input wire logic [7:0] i_paddr, // APB byte address
   input wire logic [31:0] i_pwdata, // APB write data
   output logic [31:0] o_prdata, // APB read data
   output logic o_pready, // APB ready
   output logic o_pslverr, // APB error, unmapped address
   pshwc_spi_if.host spi // Serial link to device
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      HS_IDLE, HS_GAP, HS_XFER, HS_WAKE, HS_SRST
   } pshwc_hstate_e;
   localparam int HALF_PD = (2 * HALF_SLOW >= SPI_PD_PERIOD_CYC) ?
      HALF_SLOW : (SPI_PD_PERIOD_CYC + 1) / 2;
   localparam int HGAP = (CS_HIGH_CYC > 1) ? CS_HIGH_CYC : 1;
   localparam int DW = $clog2(HALF_PD + HALF_FAST + HGAP + 1);

   pshwc_hstate_e state, next_state;
   logic [DW-1:0] div, next_div;
   logic [3:0] bits, next_bits;
   logic [15:0] txsh, next_txsh;
   logic [7:0] rx, next_rx;
   logic sclk, next_sclk, cs_n, next_cs_n, slow, next_slow;
   logic done, next_done;
   logic [1:0] step, next_step;
   logic [14:0] cmd_q, next_cmd_q;
   logic [31:0] next_prdata;
   logic miso_m, miso_s;
   logic wr, busy;
   logic [DW-1:0] half;

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         miso_m <= 1'b0;
         miso_s <= 1'b0;
      end else begin
         miso_m <= spi.miso;
         miso_s <= miso_m;
      end
   end

   assign wr = i_psel && i_penable && i_pwrite;
   assign busy = (state != HS_IDLE);
   assign half = slow ? DW'(HALF_PD) : DW'(HALF_FAST); // [R7]

   // ----------------------------------------------------------------
   // Command engine
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_div = div;
      next_bits = bits;
      next_txsh = txsh;
      next_rx = rx;
      next_sclk = sclk;
      next_cs_n = cs_n;
      next_slow = slow;
      next_done = done;
      next_step = step;
      next_cmd_q = cmd_q;
      if (wr && i_paddr == HADDR_CMD && !busy) begin
         next_cmd_q = i_pwdata[14:0];
      end
      case (state)
         HS_IDLE: begin
            if (wr && i_paddr == HADDR_CTRL) begin
               next_slow = i_pwdata[CTRL_SLOW_BIT]; // [R6]
               next_div = '0;
               next_done = 1'b0;
               if (i_pwdata[CTRL_SRST_BIT]) begin
                  next_step = 2'h2;
                  next_txsh = {1'b1, ADDR_MODE, 8'h80}; // [R13]
                  next_state = HS_GAP;
               end else if (i_pwdata[CTRL_WAKE_BIT]) begin
                  next_cs_n = 1'b0; // [R9]
                  next_state = HS_WAKE;
               end else if (i_pwdata[CTRL_START_BIT]) begin
                  next_step = 2'h0;
                  next_txsh = {i_pwdata[CTRL_WE_BIT], cmd_q};
                  next_state = HS_GAP;
               end
            end
         end
         HS_GAP: begin
            next_cs_n = 1'b1;
            if (div >= DW'(HGAP - 1)) begin
               next_div = '0; // [R13]
               next_bits = '0;
               next_cs_n = 1'b0;
               next_state = HS_XFER;
            end else begin
               next_div = div + 1'b1;
            end
         end
         HS_XFER: begin
            if (div >= half - 1'b1) begin
               next_div = '0;
               if (!sclk) begin
                  next_sclk = 1'b1;
                  next_rx = {rx[6:0], miso_s};
               end else begin
                  next_sclk = 1'b0;
                  if (bits == 4'hF) begin
                     next_cs_n = 1'b1;
                     next_state = HS_SRST;
                  end else begin
                     next_bits = bits + 1'b1;
                     next_txsh = {txsh[14:0], 1'b0};
                  end
               end
            end else begin
               next_div = div + 1'b1;
            end
         end
         HS_SRST: begin
            if (step == 2'h2) begin
               next_step = 2'h1;
               next_txsh = {1'b1, ADDR_MODE, 8'h00}; // [R13]
               next_state = HS_GAP;
            end else begin
               next_step = 2'h0;
               next_done = 1'b1;
               next_state = HS_IDLE;
            end
         end
         HS_WAKE: begin
            if (miso_s) begin
               next_cs_n = 1'b1; // [R10]
               next_done = 1'b1;
               next_state = HS_IDLE;
            end
         end
         default: next_state = HS_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // APB read data, loaded in setup cycle
   // ----------------------------------------------------------------
   always_comb begin
      next_prdata = 32'h00000000;
      case (i_paddr)
         HADDR_CTRL: next_prdata[CTRL_SLOW_BIT] = slow;
         HADDR_CMD: next_prdata[14:0] = cmd_q;
         HADDR_STAT: begin
            next_prdata[HSTAT_BUSY_BIT] = busy;
            next_prdata[HSTAT_DONE_BIT] = done;
            next_prdata[HSTAT_MISO_BIT] = miso_s;
            next_prdata[15:8] = rx;
         end
         default: next_prdata = 32'h00000000;
      endcase
      if (!(i_psel && !i_penable)) begin
         next_prdata = o_prdata;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= HS_IDLE;
         div <= '0;
         bits <= '0;
         txsh <= '0;
         rx <= '0;
         sclk <= 1'b0;
         cs_n <= 1'b1;
         slow <= 1'b0;
         done <= 1'b0;
         step <= '0;
         cmd_q <= '0;
         o_prdata <= 32'h00000000;
      end else begin
         state <= next_state;
         div <= next_div;
         bits <= next_bits;
         txsh <= next_txsh;
         rx <= next_rx;
         sclk <= next_sclk;
         cs_n <= next_cs_n;
         slow <= next_slow;
         done <= next_done;
         step <= next_step;
         cmd_q <= next_cmd_q;
         o_prdata <= next_prdata;
      end
   end

   assign o_pready = 1'b1;
   assign o_pslverr = i_psel && i_penable && (i_paddr != HADDR_CTRL) &&
      (i_paddr != HADDR_CMD) && (i_paddr != HADDR_STAT);
   assign spi.sclk = sclk; // [R12]
   assign spi.cs_n = cs_n;
   assign spi.mosi = txsh[15];
endmodule

// ### rtl/pshwc_pkg.sv
// Purpose: Shared constants for the power-state control link
// Assumes: 50 MHz system clock on both ends
// Notes: Register maps are the device's map as seen over the serial link and the host's APB map
package pshwc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int CS_HIGH_NS = 100;
   localparam int CS_HIGH_CYC = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int SPI_PD_PERIOD_NS = 100;
   localparam int SPI_PD_PERIOD_CYC =
      (SPI_PD_PERIOD_NS * CLK_MHZ + 999) / 1000;
   localparam int RAMP_US = 500;
   localparam int RAMP_CYC = RAMP_US * CLK_MHZ;
   localparam int INIT_US = 10;
   localparam int INIT_CYC = INIT_US * CLK_MHZ;
   localparam int BROWNOUT_MV = 1300;
   localparam int FRAME_BITS = 16;
   // ----------------------------------------------------------------
   // Device register map
   // ----------------------------------------------------------------
   localparam logic [6:0] ADDR_STATUS = 7'h00;
   localparam logic [6:0] ADDR_MODE = 7'h01;
   localparam logic [6:0] ADDR_FIFO = 7'h02;
   localparam logic [6:0] ADDR_FIFO_CNT = 7'h03;
   localparam logic [6:0] ADDR_SCRATCH = 7'h04;
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_BROWN_BIT = 1;
   localparam int STAT_CORE_BIT = 2;
   localparam int MODE_RST_BIT = 7;
   localparam logic [3:0] MODE_PD = 4'h0;
   localparam logic [3:0] MODE_DEEP = 4'h1;
   localparam logic [3:0] MODE_STBY = 4'h5;
   localparam logic [3:0] MODE_RX = 4'h9;
   localparam logic [3:0] MODE_TX = 4'hD;
   localparam logic [7:0] SCRATCH_RESET = 8'h00;
   // ----------------------------------------------------------------
   // Host APB register map
   // ----------------------------------------------------------------
   localparam logic [7:0] HADDR_CTRL = 8'h00;
   localparam logic [7:0] HADDR_CMD = 8'h04;
   localparam logic [7:0] HADDR_STAT = 8'h08;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_WE_BIT = 1;
   localparam int CTRL_SLOW_BIT = 2;
   localparam int CTRL_WAKE_BIT = 3;
   localparam int CTRL_SRST_BIT = 4;
   localparam int HSTAT_BUSY_BIT = 0;
   localparam int HSTAT_DONE_BIT = 1;
   localparam int HSTAT_MISO_BIT = 2;
endpackage

// ### rtl/pshwc_spi_if.sv
// Purpose: Serial link between host and power-state device
// Assumes: Slave output is pulled low when not driven
// Notes: Joins both ends; no clocking block
`timescale 1ns/1ns
interface pshwc_spi_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso_out;
   logic miso_oe;
   logic miso;
   assign miso = miso_oe ? miso_out : 1'b0;
   modport dev (input sclk, input cs_n, input mosi, output miso_out,
      output miso_oe);
   modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// ### verif/pshwc_sva.sv
// Purpose: Assertions on the power-state serial link
// Assumes: One clock, async active-low reset
// Notes: Takes link pins and device status as inputs
`timescale 1ns/1ns
module pshwc_sva import pshwc_pkg::*; (
   input wire logic i_sys_clk, // System clock
   input wire logic i_resetn, // Reset, active low
   input wire logic sclk, // Serial clock
   input wire logic cs_n, // Select, active low
   input wire logic miso_out, // Device data
   input wire logic miso_oe, // Device drives data
   input wire logic o_core_on, // Core supplies on
   input wire logic o_osc_en, // Oscillator on
   input wire logic o_reg_ready, // Supplies ready
   input wire logic o_rf_en, // Radio permitted
   input wire logic [3:0] o_mode // Power mode
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_RF_READY: assert property (o_rf_en |-> o_reg_ready && o_osc_en)
      else $error("radio on before supplies ready");
   AST_RF_MODE: assert property (o_rf_en |-> o_mode == MODE_RX ||
      o_mode == MODE_TX) else $error("radio on in wrong mode");
   AST_READY_CORE: assert property (o_reg_ready |-> o_core_on)
      else $error("ready without core supply");
   AST_CORE_OFF: assert property (!o_core_on |->
      !o_osc_en && !o_reg_ready) else $error("core off but parts still on");
   AST_OSC_MODE: assert property ($rose(o_osc_en) |->
      o_mode != MODE_PD && o_mode != MODE_DEEP)
      else $error("oscillator on in sleep mode");
   AST_INIT_LOW: assert property (o_core_on && !o_osc_en &&
      miso_oe |-> !miso_out) else $error("data high during init");
   AST_WAKE: assert property ($fell(cs_n) && !o_core_on &&
      o_mode == MODE_DEEP |-> ##[1:8] o_core_on)
      else $error("no wake on select");
   AST_MISO_REL: assert property ($rose(cs_n) |-> ##[0:6] !miso_oe)
      else $error("data still driven after deselect");
   AST_GAP: assert property ($rose(cs_n) |-> cs_n [*5])
      else $error("select gap too short");
   AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
      else $error("clock moves outside frame");
   AST_HALF: assert property ($rose(sclk) |-> sclk [*8])
      else $error("clock high phase too short");
   cover property ($rose(o_rf_en));
   cover property ($rose(o_reg_ready));
   cover property ($fell(cs_n) && o_mode == MODE_DEEP);
endmodule

// ### verif/tb_power_state_host_wake_control.sv
// Purpose: Bench for host and device joined by the serial link
// Assumes: Short ramp and init counts
// Notes: Device registers reached only through host APB registers; supply pin driven and power outputs read directly
`timescale 1ns/1ns
module tb_power_state_host_wake_control import pshwc_pkg::*; ();
   localparam int RAMP_T = 60;
   localparam int INIT_T = 20;
   localparam logic [7:0] RD = 8'h01;
   localparam logic [7:0] WR = 8'h03;
   localparam logic [7:0] RDS = 8'h05;
   localparam logic [7:0] WRS = 8'h07;
   logic clk, rstn, psel, pen, pwr, vio, prdy, perr, e;
   logic core, osc, rdy, rf;
   logic [3:0] mode;
   logic [7:0] pa;
   logic [31:0] pwd, prd, r;
   int err_count, n_checks;
   pshwc_spi_if spi_link();
   pshwc_device #(.RAMP_CYCLES(RAMP_T), .INIT_CYCLES(INIT_T)) i_pshwc_device (
      .i_sys_clk(clk), .i_resetn(rstn), .spi(spi_link), .i_vio_low(vio),
      .o_core_on(core), .o_osc_en(osc), .o_reg_ready(rdy), .o_rf_en(rf),
      .o_mode(mode));
   pshwc_host i_pshwc_host (.i_sys_clk(clk), .i_resetn(rstn),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
      .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
      .spi(spi_link));
   pshwc_sva i_pshwc_sva (.i_sys_clk(clk), .i_resetn(rstn),
      .sclk(spi_link.sclk), .cs_n(spi_link.cs_n),
      .miso_out(spi_link.miso_out), .miso_oe(spi_link.miso_oe),
      .o_core_on(core), .o_osc_en(osc), .o_reg_ready(rdy), .o_rf_en(rf),
      .o_mode(mode));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] x);
      n_checks++;
      if (g !== x) begin
         $display("Error t=%0t got=%h exp=%h", $time, g, x);
         err_count++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (prdy !== 1'b1 && k < 50);
      r = prd;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (prdy !== 1'b1) begin
         err_count++;
         stop_test();
      end
   endtask
   // Runs one link operation and waits for done
   task automatic link(input logic [7:0] c, input logic [6:0] a,
         input logic [7:0] d);
      int k;
      apb(1'b1, HADDR_CMD, {17'h0, a, d});
      apb(1'b1, HADDR_CTRL, {24'h0, c});
      k = 0;
      do begin
         apb(1'b0, HADDR_STAT, 32'h0);
         k++;
      end while (!(r[1] === 1'b1 && r[0] === 1'b0) && k < 3000);
      if (!(r[1] === 1'b1 && r[0] === 1'b0)) begin
         err_count++;
         stop_test();
      end
   endtask
   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      pen = 1'b0;
      pwr = 1'b0;
      pa = 8'h00;
      pwd = 32'h0;
      vio = 1'b0;
      err_count = 0;
      n_checks = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (INIT_T + 4) @(posedge clk);
      chk(core, 1'b0);
      chk(osc, 1'b0);
      link(RDS, ADDR_STATUS, 8'h00);
      chk(r[15:8], 8'h00);
      link(WRS, ADDR_SCRATCH, 8'h5A);
      link(RDS, ADDR_SCRATCH, 8'h00);
      chk(r[15:8], 8'h5A);
      link(WRS, ADDR_FIFO, 8'h33);
      link(RDS, ADDR_FIFO_CNT, 8'h00);
      chk(r[15:8], 8'h00);
      link(WRS, ADDR_MODE, {4'h0, MODE_RX});
      chk(rdy, 1'b0);
      repeat (RAMP_T + 20) @(posedge clk);
      chk(rf, 1'b1);
      chk(osc, 1'b1);
      link(RD, ADDR_STATUS, 8'h00);
      chk(r[15:8], 8'h05);
      link(WR, ADDR_FIFO, 8'h33);
      link(RD, ADDR_FIFO_CNT, 8'h00);
      chk(r[15:8], 8'h01);
      link(WR, ADDR_FIFO, 8'h44);
      link(RD, ADDR_FIFO, 8'h00);
      chk(r[15:8], 8'h33);
      link(WR, ADDR_MODE, {4'h0, MODE_PD});
      chk(core, 1'b0);
      link(RDS, ADDR_FIFO_CNT, 8'h00);
      chk(r[15:8], 8'h00);
      link(RDS, ADDR_SCRATCH, 8'h00);
      chk(r[15:8], 8'h5A);
      link(RDS, ADDR_FIFO, 8'h00);
      chk(r[15:8], 8'h00);
      vio <= 1'b1;
      repeat (5) @(posedge clk);
      vio <= 1'b0;
      link(RDS, ADDR_STATUS, 8'h00);
      chk(r[15:8], 8'h02);
      link(RDS, ADDR_STATUS, 8'h00);
      chk(r[15:8], 8'h00);
      link(8'h14, 7'h00, 8'h00);
      link(RDS, ADDR_SCRATCH, 8'h00);
      chk(r[15:8], SCRATCH_RESET);
      link(WRS, ADDR_SCRATCH, 8'h77);
      link(WRS, ADDR_MODE, {4'h0, MODE_DEEP});
      repeat (10) @(posedge clk);
      chk(mode, MODE_DEEP);
      link(8'h08, 7'h00, 8'h00);
      chk(r[2], 1'b1);
      chk(mode, MODE_PD);
      link(RDS, ADDR_SCRATCH, 8'h00);
      chk(r[15:8], 8'h00);
      apb(1'b0, 8'hFC, 32'h0);
      chk(e, 1'b1);
      chk(r[7:0], 8'h00);
      stop_test();
   end
endmodule
